// *** core/clock_gate_bank_defs.vh ***
// register map, field positions and reset values of the clock gate bank
`ifndef CLOCK_GATE_BANK_DEFS_VH
`define CLOCK_GATE_BANK_DEFS_VH

// register byte offsets
`define CG_OFF_CTRL_2        12'h168
`define CG_OFF_CTRL_3        12'h16c
`define CG_OFF_CTRL_4        12'h170
`define CG_OFF_CTRL_5        12'h174
`define CG_OFF_CTRL_6        12'h178
`define CG_OFF_CTRL_7        12'h17c

// field layout of every gating register
`define CG_GATE_LSB          0
`define CG_GATE_MSB          15
`define CG_MASK_LSB          16
`define CG_MASK_MSB          31

// reset value of the gate field
`define CG_GATE_RESET        16'h0000

// gate bits that exist in each register; the others are reserved and read zero
`define CG_WR_CTRL_2         16'h006f
`define CG_WR_CTRL_3         16'hfeff
`define CG_WR_CTRL_4         16'hffff
`define CG_WR_CTRL_5         16'hffff
`define CG_WR_CTRL_6         16'hfbff
`define CG_WR_CTRL_7         16'hffff

// gating register two
`define CG2_PERI_SRC         0
`define CG2_PERI_AXI         1
`define CG2_PERI_HS_BUS      2
`define CG2_PERI_REG_BUS     3
// gating register three
`define CG3_DISP_A_AXI       0
`define CG3_DISP_A_PIXEL     1
`define CG3_DISP_B_AXI       2
`define CG3_DISP_B_PIXEL     3
// gating register four
`define CG4_AUDIO_OUT        0
`define CG4_AUDIO_SRC        1
`define CG4_AUDIO_FRAC       2
`define CG4_AUDIO_MAIN       3
`define CG4_SCAN_TEST        14
`define CG4_TEST_OUT         15
// gating register five
`define CG5_MAC_RX           0
`define CG5_MAC_TX           1
`define CG5_MAC_REF          2
`define CG5_MAC_REFOUT       3
// gating register six
`define CG6_PERI_MATRIX_HS   0
`define CG6_PERI_MATRIX_REG  1
`define CG6_PERI_MATRIX_AXI  2
`define CG6_PERI_DMA_AXI     3
`define CG6_SERIAL_A         4
`define CG6_SERIAL_B         5
`define CG6_SERIAL_C         6
// gating register seven
`define CG7_USB_BUS          4
`define CG7_USB_POWER_BUS    5
`define CG7_FLASH_A          14
`define CG7_FLASH_B          15

`endif

// *** core/clock_stop_stage.v ***
// retiming stage that presents gate levels to the clock gating cells
`timescale 1ns/1ns
`default_nettype none

module clock_stop_stage (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [15:0] stop_req,
  output wire [15:0] stop
);

  reg [15:0] stop_q;

  // levels move only just after a rising edge and stay put through the low
  // phase, where the latch-based gating cells sample them; this keeps a
  // stopped or restarted clock free of shortened pulses
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stop_q <= 16'h0000; // [R4]
    end else begin
      stop_q <= stop_req; // [R15]
    end
  end

  assign stop = stop_q;

endmodule // clock_stop_stage

`default_nettype wire

// *** core/masked_gate_reg.v ***
// one gating register: gate bits written under the per-bit mask of the upper half
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_bank_defs.vh"

module masked_gate_reg #(
  parameter [15:0] WRITABLE = 16'hffff
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  output wire [15:0] gate
);

  reg  [15:0] gate_q;
  wire [15:0] sel;
  wire [15:0] gate_d;

  // only bits with their mask bit set follow the write; reserved bits never move
  assign sel    = wr_data[`CG_MASK_MSB:`CG_MASK_LSB] & WRITABLE; // [R1] [R2] [R14]
  assign gate_d = (gate_q & ~sel) | (wr_data[`CG_GATE_MSB:`CG_GATE_LSB] & sel); // [R1] [R2]

  // the mask half is not stored, so it cannot read back anything but zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gate_q <= `CG_GATE_RESET; // [R4]
    end else if (wr_en) begin
      gate_q <= gate_d;
    end
  end

  assign gate = gate_q;

endmodule // masked_gate_reg

`default_nettype wire

// *** core/peripheral_clock_gate_bank.v ***
// bank of masked clock gating registers behind an apb slave
//
// Behaviour
// R1: on a write, each gate bit whose upper-half mask bit is 1 takes the written value.
// R2: on a write, each gate bit whose upper-half mask bit is 0 keeps its value.
// R3: a gate bit at 1 stops its clock, a gate bit at 0 lets it run.
// R4: after reset all gate and mask bits read zero, so every clock runs.
// R5: register two bits 3..0 stop the peripheral register-bus, high-speed-bus, axi and source clocks.
// R6: register three bits 0..3 stop display a axi and pixel, then display b axi and pixel clocks.
// R7: register four bit 14 stops the boundary-scan clock and bit 15 the test output clock.
// R8: register four bits 0..3 stop audio output, source, fractional source and main clocks.
// R9: register five bits 0..2 stop ethernet receive, transmit, reference, bit 3 reference output.
// R10: register six bits 4..6 stop the bus clocks of serial controllers a, b and c.
// R11: register six bit 3 stops peripheral dma axi, bits 2..0 matrix axi, register-bus, high-speed-bus.
// R12: register seven bits 15 and 14 stop the bus clocks of flash controllers b and a.
// R13: register seven bit 4 stops the usb dual-role bus clock and bit 5 its power bus clock.
// R14: reserved bits and the mask field read zero and writes to reserved bits do nothing; register seven keeps its reserved bit 8 writable.
// R15: gate changes are applied glitch-free, during the clock low phase.
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_bank_defs.vh"

module peripheral_clock_gate_bank (
  input  wire        ref_clk,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // whole stop vectors, one per gating register
  output wire [15:0] stop_vec_2,
  output wire [15:0] stop_vec_3,
  output wire [15:0] stop_vec_4,
  output wire [15:0] stop_vec_5,
  output wire [15:0] stop_vec_6,
  output wire [15:0] stop_vec_7,
  // register two
  output wire        peri_source_clock_stop,
  output wire        peri_axi_clock_stop,
  output wire        peri_hs_bus_clock_stop,
  output wire        peri_reg_bus_clock_stop,
  // register three
  output wire        display_a_axi_clock_stop,
  output wire        display_a_pixel_clock_stop,
  output wire        display_b_axi_clock_stop,
  output wire        display_b_pixel_clock_stop,
  // register four
  output wire        audio_out_clock_stop,
  output wire        audio_source_clock_stop,
  output wire        audio_frac_source_clock_stop,
  output wire        audio_main_clock_stop,
  output wire        scan_test_clock_stop,
  output wire        test_out_clock_stop,
  // register five
  output wire        mac_rx_clock_stop,
  output wire        mac_tx_clock_stop,
  output wire        mac_ref_clock_stop,
  output wire        mac_refout_clock_stop,
  // register six
  output wire        peri_matrix_hs_bus_clock_stop,
  output wire        peri_matrix_reg_bus_clock_stop,
  output wire        peri_matrix_axi_clock_stop,
  output wire        peri_dma_axi_clock_stop,
  output wire        serial_ctrl_a_bus_clock_stop,
  output wire        serial_ctrl_b_bus_clock_stop,
  output wire        serial_ctrl_c_bus_clock_stop,
  // register seven
  output wire        usb_dual_role_bus_clock_stop,
  output wire        usb_dual_role_power_bus_clock_stop,
  output wire        flash_ctrl_a_bus_clock_stop,
  output wire        flash_ctrl_b_bus_clock_stop
);

  // register index used by the decoder
  localparam [2:0] IDX_2    = 3'h0;
  localparam [2:0] IDX_3    = 3'h1;
  localparam [2:0] IDX_4    = 3'h2;
  localparam [2:0] IDX_5    = 3'h3;
  localparam [2:0] IDX_6    = 3'h4;
  localparam [2:0] IDX_7    = 3'h5;
  localparam [2:0] IDX_NONE = 3'h7;

  // map a byte address onto a register index; misaligned or unknown is none
  function [2:0] reg_index;
    input [11:0] addr;
    begin
      case (addr)
        `CG_OFF_CTRL_2: reg_index = IDX_2;
        `CG_OFF_CTRL_3: reg_index = IDX_3;
        `CG_OFF_CTRL_4: reg_index = IDX_4;
        `CG_OFF_CTRL_5: reg_index = IDX_5;
        `CG_OFF_CTRL_6: reg_index = IDX_6;
        `CG_OFF_CTRL_7: reg_index = IDX_7;
        default:        reg_index = IDX_NONE;
      endcase
    end
  endfunction

  // place a gate field in the low half of a read word; the write-only mask half reads zero
  function [31:0] read_word;
    input [15:0] gate;
    begin
      read_word = 32'h0000_0000;
      read_word[`CG_GATE_MSB:`CG_GATE_LSB] = gate; // [R14]
    end
  endfunction

  // write strobe of one register; the decode is the one held since the setup cycle
  function write_hit;
    input       ok;
    input [2:0] held;
    input [2:0] which;
    begin
      write_hit = ok & (held == which);
    end
  endfunction

  // bus state
  reg         pready_q;
  reg         pslverr_q;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;
  reg  [2:0]  idx_q;
  wire [2:0]  idx;
  wire        setup_phase;
  wire        access_done;
  wire        wr_ok;
  wire [5:0]  wr_sel;

  // gate register contents
  wire [15:0] gate_2;
  wire [15:0] gate_3;
  wire [15:0] gate_4;
  wire [15:0] gate_5;
  wire [15:0] gate_6;
  wire [15:0] gate_7;

  // decode and phase of the transfer on the bus
  assign idx         = reg_index(paddr);
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_q;

  // a write lands only at the completing edge and only with all byte lanes
  // set; partial writes would split the mask from its gate bits, so they are
  // refused with an error and change nothing
  assign wr_ok = access_done & pwrite & ~pslverr_q;

  // the write lands in the register picked at setup, so an address that
  // wanders during the access phase cannot redirect it
  assign wr_sel[0] = write_hit(wr_ok, idx_q, IDX_2); // [R1] [R2]
  assign wr_sel[1] = write_hit(wr_ok, idx_q, IDX_3);
  assign wr_sel[2] = write_hit(wr_ok, idx_q, IDX_4);
  assign wr_sel[3] = write_hit(wr_ok, idx_q, IDX_5);
  assign wr_sel[4] = write_hit(wr_ok, idx_q, IDX_6);
  assign wr_sel[5] = write_hit(wr_ok, idx_q, IDX_7);

  // read mux; the mask half is write-only and reads zero
  always @* begin
    prdata_d = 32'h0000_0000;
    case (idx)
      IDX_2:   prdata_d = read_word(gate_2); // [R14]
      IDX_3:   prdata_d = read_word(gate_3);
      IDX_4:   prdata_d = read_word(gate_4);
      IDX_5:   prdata_d = read_word(gate_5);
      IDX_6:   prdata_d = read_word(gate_6);
      IDX_7:   prdata_d = read_word(gate_7);
      default: prdata_d = 32'h0000_0000;
    endcase
  end

  // no wait state: the answer is prepared in the setup cycle and pready
  // rises in the first access cycle, so every output stays a flip-flop;
  // the decode is held until the completing edge, and an error answer
  // keeps the write from landing anywhere
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0; // [R4]
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      idx_q     <= IDX_NONE;
    end else if (setup_phase) begin
      pready_q  <= 1'b1;
      idx_q     <= idx;
      pslverr_q <= (idx == IDX_NONE) | (pwrite & (pstrb != 4'hf));
      prdata_q  <= pwrite ? 32'h0000_0000 : prdata_d;
    end else if (access_done) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
  end

  // bus outputs straight from their flip-flops
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // gating registers, each with its own set of implemented bits
  // register two: only bits 6, 5 and 3..0 of this stretch exist
  masked_gate_reg #(.WRITABLE(`CG_WR_CTRL_2)) u_reg_2 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_sel[0]),
    .wr_data (pwdata),
    .gate    (gate_2)
  );

  // register three: bit 8 is reserved and read-only
  masked_gate_reg #(.WRITABLE(`CG_WR_CTRL_3)) u_reg_3 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_sel[1]),
    .wr_data (pwdata),
    .gate    (gate_3)
  );

  // register four: every gate bit is implemented
  masked_gate_reg #(.WRITABLE(`CG_WR_CTRL_4)) u_reg_4 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_sel[2]),
    .wr_data (pwdata),
    .gate    (gate_4)
  );

  // register five: every gate bit is implemented
  masked_gate_reg #(.WRITABLE(`CG_WR_CTRL_5)) u_reg_5 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_sel[3]),
    .wr_data (pwdata),
    .gate    (gate_5)
  );

  // register six: bit 10 is reserved and read-only
  masked_gate_reg #(.WRITABLE(`CG_WR_CTRL_6)) u_reg_6 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_sel[4]),
    .wr_data (pwdata),
    .gate    (gate_6)
  );

  // register seven: bit 8 is reserved but kept writable
  masked_gate_reg #(.WRITABLE(`CG_WR_CTRL_7)) u_reg_7 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_sel[5]),
    .wr_data (pwdata),
    .gate    (gate_7)
  );

  // retimed stop levels toward the gating cells; a bit at 1 stops its clock
  // one extra cycle of latency is the price of a clean hand-over to the cells
  clock_stop_stage u_stage_2 (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .stop_req (gate_2), // [R3]
    .stop     (stop_vec_2)
  );

  clock_stop_stage u_stage_3 (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .stop_req (gate_3), // [R3]
    .stop     (stop_vec_3)
  );

  clock_stop_stage u_stage_4 (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .stop_req (gate_4), // [R3]
    .stop     (stop_vec_4)
  );

  clock_stop_stage u_stage_5 (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .stop_req (gate_5), // [R3]
    .stop     (stop_vec_5)
  );

  clock_stop_stage u_stage_6 (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .stop_req (gate_6), // [R3]
    .stop     (stop_vec_6)
  );

  clock_stop_stage u_stage_7 (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .stop_req (gate_7), // [R3]
    .stop     (stop_vec_7)
  );

  // peripheral domain clocks of register two
  assign peri_source_clock_stop  = stop_vec_2[`CG2_PERI_SRC];    // [R5]
  assign peri_axi_clock_stop     = stop_vec_2[`CG2_PERI_AXI];    // [R5]
  assign peri_hs_bus_clock_stop  = stop_vec_2[`CG2_PERI_HS_BUS]; // [R5]
  assign peri_reg_bus_clock_stop = stop_vec_2[`CG2_PERI_REG_BUS]; // [R5]

  // display controller clocks of register three
  assign display_a_axi_clock_stop   = stop_vec_3[`CG3_DISP_A_AXI];   // [R6]
  assign display_a_pixel_clock_stop = stop_vec_3[`CG3_DISP_A_PIXEL]; // [R6]
  assign display_b_axi_clock_stop   = stop_vec_3[`CG3_DISP_B_AXI];   // [R6]
  assign display_b_pixel_clock_stop = stop_vec_3[`CG3_DISP_B_PIXEL]; // [R6]

  // audio and test clocks of register four
  assign audio_out_clock_stop         = stop_vec_4[`CG4_AUDIO_OUT];  // [R8]
  assign audio_source_clock_stop      = stop_vec_4[`CG4_AUDIO_SRC];  // [R8]
  assign audio_frac_source_clock_stop = stop_vec_4[`CG4_AUDIO_FRAC]; // [R8]
  assign audio_main_clock_stop        = stop_vec_4[`CG4_AUDIO_MAIN]; // [R8]
  assign scan_test_clock_stop         = stop_vec_4[`CG4_SCAN_TEST];  // [R7]
  assign test_out_clock_stop          = stop_vec_4[`CG4_TEST_OUT];   // [R7]

  // ethernet clocks of register five
  assign mac_rx_clock_stop     = stop_vec_5[`CG5_MAC_RX];     // [R9]
  assign mac_tx_clock_stop     = stop_vec_5[`CG5_MAC_TX];     // [R9]
  assign mac_ref_clock_stop    = stop_vec_5[`CG5_MAC_REF];    // [R9]
  assign mac_refout_clock_stop = stop_vec_5[`CG5_MAC_REFOUT]; // [R9]

  // peripheral matrix, dma and serial controller clocks of register six
  assign peri_matrix_hs_bus_clock_stop  = stop_vec_6[`CG6_PERI_MATRIX_HS];  // [R11]
  assign peri_matrix_reg_bus_clock_stop = stop_vec_6[`CG6_PERI_MATRIX_REG]; // [R11]
  assign peri_matrix_axi_clock_stop     = stop_vec_6[`CG6_PERI_MATRIX_AXI]; // [R11]
  assign peri_dma_axi_clock_stop        = stop_vec_6[`CG6_PERI_DMA_AXI];    // [R11]
  assign serial_ctrl_a_bus_clock_stop   = stop_vec_6[`CG6_SERIAL_A];        // [R10]
  assign serial_ctrl_b_bus_clock_stop   = stop_vec_6[`CG6_SERIAL_B];        // [R10]
  assign serial_ctrl_c_bus_clock_stop   = stop_vec_6[`CG6_SERIAL_C];        // [R10]

  // usb and flash controller clocks of register seven
  assign usb_dual_role_bus_clock_stop       = stop_vec_7[`CG7_USB_BUS];       // [R13]
  assign usb_dual_role_power_bus_clock_stop = stop_vec_7[`CG7_USB_POWER_BUS]; // [R13]
  assign flash_ctrl_a_bus_clock_stop        = stop_vec_7[`CG7_FLASH_A];       // [R12]
  assign flash_ctrl_b_bus_clock_stop        = stop_vec_7[`CG7_FLASH_B];       // [R12]

endmodule // peripheral_clock_gate_bank

`default_nettype wire

// *** verification/gate_bank_checker_sva.sv ***
// concurrent checks on the apb answer and stop outputs of the clock gate bank
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_bank_defs.vh"
module gate_bank_checker (
  input wire        ref_clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [15:0] stop_vec_3,
  input wire        display_a_axi_clock_stop,
  input wire        display_b_pixel_clock_stop
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // completing access, its decode, and a full-strobe write to register three
  wire done   = psel && penable && pready;
  wire mapped = paddr >= `CG_OFF_CTRL_2 && paddr <= `CG_OFF_CTRL_7 && paddr[1:0] == 2'b00;
  wire wr3    = done && pwrite && paddr == `CG_OFF_CTRL_3 && pstrb == 4'hf;

  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  mask_reads_zero_a: assert property (done && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("mask field read back nonzero");
  unmapped_err_a: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  strobe_err_a: assert property (done && pwrite && pstrb != 4'hf |-> pslverr)
    else $error("partial strobe write not refused");
  gate_write_a: assert property (wr3 && pwdata[16] |-> ##2 display_a_axi_clock_stop == $past(pwdata[0], 2))
    else $error("masked gate bit not taken");
  gate_hold_a: assert property (wr3 && !pwdata[19] |-> ##2 $stable(display_b_pixel_clock_stop))
    else $error("unmasked gate bit changed");
  stop_cause_a: assert property ($changed(stop_vec_3) |-> $past(wr3, 2))
    else $error("stop level moved without a write");
  named_bits_a: assert property (display_a_axi_clock_stop == stop_vec_3[0] && display_b_pixel_clock_stop == stop_vec_3[3])
    else $error("named stop differs from vector bit");
  reset_clear_a: assert property ($rose(resetn) |-> stop_vec_3 == 16'h0000)
    else $error("stop vector not clear after reset");
endmodule // gate_bank_checker
`default_nettype wire

// *** verification/test_peripheral_clock_gate_bank.sv ***
// self-checking bench for the clock gate bank
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_bank_defs.vh"
module test_peripheral_clock_gate_bank;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] sv [2:7];
  wire  [3:0]  n2, n3, n5, n7;
  wire  [5:0]  n4;
  wire  [6:0]  n6;
  integer      failures = 0;
  integer      cmp_count = 0;
  logic [31:0] rd;
  logic        er;
  // rows: address, write word, gate value expected afterwards
  logic [59:0] rows [9] = '{
    {`CG_OFF_CTRL_2, 32'hffff_ffff, 16'h006f}, {`CG_OFF_CTRL_2, 32'h0005_0000, 16'h006a},
    {`CG_OFF_CTRL_3, 32'h000f_000a, 16'h000a}, {`CG_OFF_CTRL_3, 32'h0100_0100, 16'h000a},
    {`CG_OFF_CTRL_4, 32'hc00f_4005, 16'h4005}, {`CG_OFF_CTRL_5, 32'h000f_0005, 16'h0005},
    {`CG_OFF_CTRL_6, 32'h047f_0455, 16'h0055}, {`CG_OFF_CTRL_7, 32'hc030_ffff, 16'hc030},
    {`CG_OFF_CTRL_7, 32'h4010_0000, 16'h8020}};

  peripheral_clock_gate_bank peripheral_clock_gate_bank_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_vec_2(sv[2]), .stop_vec_3(sv[3]), .stop_vec_4(sv[4]),
    .stop_vec_5(sv[5]), .stop_vec_6(sv[6]), .stop_vec_7(sv[7]),
    .peri_source_clock_stop(n2[0]), .peri_axi_clock_stop(n2[1]),
    .peri_hs_bus_clock_stop(n2[2]), .peri_reg_bus_clock_stop(n2[3]),
    .display_a_axi_clock_stop(n3[0]), .display_a_pixel_clock_stop(n3[1]),
    .display_b_axi_clock_stop(n3[2]), .display_b_pixel_clock_stop(n3[3]),
    .audio_out_clock_stop(n4[0]), .audio_source_clock_stop(n4[1]), .audio_frac_source_clock_stop(n4[2]),
    .audio_main_clock_stop(n4[3]), .scan_test_clock_stop(n4[4]), .test_out_clock_stop(n4[5]),
    .mac_rx_clock_stop(n5[0]), .mac_tx_clock_stop(n5[1]), .mac_ref_clock_stop(n5[2]),
    .mac_refout_clock_stop(n5[3]),
    .peri_matrix_hs_bus_clock_stop(n6[0]), .peri_matrix_reg_bus_clock_stop(n6[1]),
    .peri_matrix_axi_clock_stop(n6[2]), .peri_dma_axi_clock_stop(n6[3]),
    .serial_ctrl_a_bus_clock_stop(n6[4]), .serial_ctrl_b_bus_clock_stop(n6[5]),
    .serial_ctrl_c_bus_clock_stop(n6[6]),
    .usb_dual_role_bus_clock_stop(n7[0]), .usb_dual_role_power_bus_clock_stop(n7[1]),
    .flash_ctrl_a_bus_clock_stop(n7[2]), .flash_ctrl_b_bus_clock_stop(n7[3])
  );

  // 25 mhz reference clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; pready, read data and error are taken at the completing rising edge,
  // before the slave's own updates of that edge land, and only then is the request released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    integer n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] sv_of(input logic [11:0] a);
    return sv[(a - `CG_OFF_CTRL_2) / 4 + 2];
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    integer i;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(`CG_OFF_CTRL_2 + 4 * i), 32'h0, 4'hf);
      check("reset read", 32'h0, rd);
      check("reset stop", 32'h0, {16'h0, sv[i + 2]});
    end
    // write each row, read it back, then look at the stop vector it drives
    for (i = 0; i < 9; i++) begin
      apb(1'b1, rows[i][59:48], rows[i][47:16], 4'hf);
      check("write err", 32'h0, {31'h0, er});
      apb(1'b0, rows[i][59:48], 32'h0, 4'hf);
      check("read err", 32'h0, {31'h0, er});
      check("gate read", {16'h0, rows[i][15:0]}, rd);
      check("stop vector", {16'h0, rows[i][15:0]}, {16'h0, sv_of(rows[i][59:48])});
    end
    check("reg two names", 32'ha, {28'h0, n2});
    check("reg three names", 32'ha, {28'h0, n3});
    check("reg four names", 32'h15, {26'h0, n4});
    check("reg five names", 32'h5, {28'h0, n5});
    check("reg six names", 32'h55, {25'h0, n6});
    check("reg seven names", 32'ha, {28'h0, n7});
    // unmapped place and partial strobes are refused without side effects
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    check("unmapped data", 32'h0, rd);
    check("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, `CG_OFF_CTRL_3, 32'h00f0_00f0, 4'h3);
    check("strobe err", 32'h1, {31'h0, er});
    apb(1'b0, `CG_OFF_CTRL_3, 32'h0, 4'hf);
    check("after refused write", 32'h000a, rd);
    // a second reset in mid-run restarts every clock
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("stop in reset", 32'h0, {16'h0, sv[7]});
    resetn <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, `CG_OFF_CTRL_7, 32'h0, 4'hf);
    check("read after reset", 32'h0, rd);
    report_and_stop;
  end

  // watchdog, far beyond the roughly one hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    report_and_stop;
  end
endmodule // test_peripheral_clock_gate_bank

bind peripheral_clock_gate_bank gate_bank_checker gate_bank_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_vec_3(stop_vec_3), .display_a_axi_clock_stop(display_a_axi_clock_stop),
  .display_b_pixel_clock_stop(display_b_pixel_clock_stop)
);
`default_nettype wire
